// File: rpc_defs.svh
`ifndef RPC_DEFS_SVH
`define RPC_DEFS_SVH

// Data path width of one code element and default port count.
`define RPC_DW 4
`define RPC_N_PORTS 4

// Core clock period in ns and time-to-cycle conversions.
`define RPC_CLK_NS 10
`define RPC_CYC_UP(t) (((t) + `RPC_CLK_NS - 1) / `RPC_CLK_NS)
`define RPC_CYC_DN(t) ((t) / `RPC_CLK_NS)

// Protection timers in ns and event limits.
`define RPC_JAB_NS 50000
`define RPC_FC_NS 4000
`define RPC_IDLE_NS 33000
`define RPC_FCC_LIMIT 4'h2
`define RPC_PART_LIMIT 6'h1e

// Outgoing code values per symbol class and PHY type.
`define RPC_CODE_IDLE 4'h0
`define RPC_CODE_PRE_T0 4'h5
`define RPC_CODE_PRE_T1 4'h5
`define RPC_CODE_PRE_T2 4'ha
`define RPC_CODE_SFD 4'hd
`define RPC_CODE_EOF 4'he
`define RPC_CODE_BAD_T0 4'h1
`define RPC_CODE_BAD_T1 4'h4
`define RPC_CODE_BAD_T2 4'h7
`define RPC_CODE_JAM 4'h5

`endif

// File: rpc_pkg.sv
`include "rpc_defs.svh"

package rpc_pkg;

  // Symbol class carried beside each code element.
  typedef enum logic [2:0] {SYM_IDLE, SYM_PRE, SYM_SFD, SYM_DATA, SYM_EOF, SYM_BAD, SYM_JAM}
    rpc_sym_e;

  // Repeater core states.
  typedef enum logic [1:0] {ST_IDLE, ST_FWD, ST_JAM} rpc_state_e;

  // Outgoing PHY type selector; 2'h3 is not a valid type.
  typedef logic [1:0] rpc_phy_t;

  // One buffered code element.
  typedef struct packed {
    rpc_sym_e sym;
    logic [`RPC_DW-1:0] data;
  } rpc_ent_s;

endpackage

// File: rpc_buf_if.sv
`timescale 1ns/100ps

// Carrier between the core and its two-entry buffer.
interface rpc_buf_if;
  import rpc_pkg::*;
  logic wr_valid;
  logic wr_ready;
  rpc_ent_s wr_data;
  logic flush;
  logic rd_valid;
  logic rd_ready;
  rpc_ent_s rd_data;
  modport src (output wr_valid, output wr_data, output flush, input wr_ready,
               input rd_valid, input rd_data, output rd_ready);
  modport fifo (input wr_valid, input wr_data, input flush, output wr_ready,
                output rd_valid, output rd_data, input rd_ready);
endinterface

// File: rpc_buf2.sv
`timescale 1ns/100ps
`include "rpc_defs.svh"

module rpc_buf2
  import rpc_pkg::*;
(
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst,
  // Buffer ports.
  rpc_buf_if.fifo bus
);

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  rpc_ent_s mem_r [2];
  rpc_ent_s mem_nxt [2];
  logic head_r;
  logic head_nxt;
  logic [1:0] cnt_r;
  logic [1:0] cnt_nxt;
  logic push;
  logic pop;

  // A full buffer still takes a word while one leaves, so a single stall loses nothing.
  assign bus.wr_ready = (cnt_r != 2'h2) || bus.rd_ready;
  assign bus.rd_valid = (cnt_r != 2'h0);
  assign bus.rd_data = mem_r[head_r];
  assign push = bus.wr_valid && bus.wr_ready;
  assign pop = bus.rd_valid && bus.rd_ready;

  // Flush wins over both sides, so a jam never replays stale words.
  always_comb
  begin
    mem_nxt = mem_r;
    head_nxt = head_r;
    cnt_nxt = cnt_r;
    if (bus.flush)
    begin
      cnt_nxt = 2'h0;
    end
    else
    begin
      if (push)
      begin
        mem_nxt[head_r ^ cnt_r[0]] = bus.wr_data;
      end
      if (pop)
      begin
        head_nxt = ~head_r;
      end
      cnt_nxt = cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      mem_r[0] <= '0;
      mem_r[1] <= '0;
      head_r <= 1'b0;
      cnt_r <= 2'h0;
    end
    else
    begin
      mem_r <= mem_nxt;
      head_r <= head_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  a_cut_through: assert property ((push && cnt_r == 2'h0 && !bus.flush) |=>
    (bus.rd_valid && bus.rd_data == $past(bus.wr_data)))
    else $error("Buffered word not offered on the next cycle.");

endmodule // rpc_buf2

// File: rpc_core.sv
`timescale 1ns/100ps
`include "rpc_defs.svh"

module rpc_core
  import rpc_pkg::*;
#(
  parameter int N_PORTS = `RPC_N_PORTS,
  parameter logic [15:0] JAB_CYC = 16'(`RPC_CYC_DN(`RPC_JAB_NS)),
  parameter logic [15:0] FC_CYC = 16'(`RPC_CYC_DN(`RPC_FC_NS)),
  parameter logic [15:0] IDLE_CYC = 16'(`RPC_CYC_UP(`RPC_IDLE_NS))
)
(
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst,
  // Receive primitives per port.
  input wire logic [N_PORTS-1:0] i_rx_carrier,
  input wire logic [N_PORTS-1:0] i_rx_link,
  input wire logic [N_PORTS-1:0] i_rx_err,
  input wire rpc_sym_e i_rx_sym [N_PORTS],
  input wire logic [`RPC_DW-1:0] i_rx_data [N_PORTS],
  input wire rpc_phy_t i_phy_type [N_PORTS],
  // Transmit primitives per port.
  input wire logic i_tx_ready,
  output logic [N_PORTS-1:0] o_tx_valid,
  output rpc_sym_e o_tx_sym [N_PORTS],
  output logic [`RPC_DW-1:0] o_tx_code [N_PORTS],
  // Status.
  output logic o_collision,
  output logic [N_PORTS-1:0] o_partitioned,
  output logic [N_PORTS-1:0] o_jabber,
  output logic [N_PORTS-1:0] o_unstable
);

  localparam int IW = (N_PORTS > 1) ? $clog2(N_PORTS) : 1;
  localparam logic [3:0] FCC_LIM = `RPC_FCC_LIMIT;
  localparam logic [5:0] PART_LIM = `RPC_PART_LIMIT;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  // Saturating count of set bits: 0, 1 or 2 meaning two or more.
  function automatic logic [1:0] count_sat(input logic [N_PORTS-1:0] v);
    logic [1:0] c;
    c = 2'h0;
    for (int i = 0; i < N_PORTS; i++)
    begin
      if (v[i] && c != 2'h2)
      begin
        c = c + 2'h1;
      end
    end
    return c;
  endfunction

  // Index of the single set bit of a one-hot vector.
  function automatic logic [IW-1:0] onehot_idx(input logic [N_PORTS-1:0] v);
    logic [IW-1:0] r;
    r = '0;
    for (int i = 0; i < N_PORTS; i++)
    begin
      if (v[i])
      begin
        r = IW'(i);
      end
    end
    return r;
  endfunction

  // Outgoing code for a symbol class on a given PHY type.
  function automatic logic [`RPC_DW-1:0] encode(input rpc_phy_t t, input rpc_sym_e s,
                                                input logic [`RPC_DW-1:0] d);
    logic [`RPC_DW-1:0] c;
    c = `RPC_CODE_IDLE;
    unique case (s)
      SYM_IDLE: c = `RPC_CODE_IDLE;
      SYM_PRE:
        case (t)
          2'h0: c = `RPC_CODE_PRE_T0;
          2'h1: c = `RPC_CODE_PRE_T1;
          default: c = `RPC_CODE_PRE_T2;
        endcase
      SYM_SFD: c = `RPC_CODE_SFD;
      SYM_DATA: c = d;
      SYM_EOF: c = `RPC_CODE_EOF;
      SYM_BAD:
        case (t)
          2'h0: c = `RPC_CODE_BAD_T0;
          2'h1: c = `RPC_CODE_BAD_T1;
          default: c = `RPC_CODE_BAD_T2;
        endcase
      SYM_JAM: c = `RPC_CODE_JAM;
    endcase
    return c;
  endfunction

  rpc_buf_if bif ();

  rpc_buf2 u_buf (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .bus(bif.fifo)
  );

  rpc_state_e state_r;
  rpc_state_e state_nxt;
  logic [IW-1:0] src_r;
  logic [IW-1:0] src_nxt;
  logic err_r;
  logic err_nxt;
  logic in_frame_r;
  logic in_frame_nxt;
  logic [N_PORTS-1:0] act;
  logic [N_PORTS-1:0] cand;
  logic [1:0] ncand;
  logic [1:0] nact;
  logic col_end;
  logic clean_end;
  rpc_sym_e fwd_sym;
  logic [15:0] jab_cnt_r [N_PORTS];
  logic [15:0] jab_cnt_nxt [N_PORTS];
  logic [15:0] fc_tmr_r [N_PORTS];
  logic [15:0] fc_tmr_nxt [N_PORTS];
  logic [15:0] idle_cnt_r [N_PORTS];
  logic [15:0] idle_cnt_nxt [N_PORTS];
  logic [3:0] fc_cnt_r [N_PORTS];
  logic [3:0] fc_cnt_nxt [N_PORTS];
  logic [5:0] part_cnt_r [N_PORTS];
  logic [5:0] part_cnt_nxt [N_PORTS];
  logic [N_PORTS-1:0] in_evt_r, in_evt_nxt, false_r, false_nxt, seen_r, seen_nxt;
  logic [N_PORTS-1:0] solo_r, solo_nxt, part_r, part_nxt, jab_r, jab_nxt;
  logic [N_PORTS-1:0] unst_r, unst_nxt;
  rpc_sym_e tx_sym_r [N_PORTS];
  rpc_sym_e tx_sym_nxt [N_PORTS];
  logic [`RPC_DW-1:0] tx_code_r [N_PORTS];
  logic [`RPC_DW-1:0] tx_code_nxt [N_PORTS];

  // Carrier present means carrier and link up and not idle; eligible ports feed the core.
  always_comb
  begin
    for (int p = 0; p < N_PORTS; p++)
    begin
      act[p] = i_rx_carrier[p] && i_rx_link[p] && (i_rx_sym[p] != SYM_IDLE);
      cand[p] = act[p] && !part_r[p] && !jab_r[p] && !unst_r[p];
    end
    ncand = count_sat(cand);
    nact = count_sat(act);
  end

  // Core state, source selection and sticky error substitution.
  always_comb
  begin
    state_nxt = state_r;
    src_nxt = src_r;
    err_nxt = err_r;
    in_frame_nxt = in_frame_r;
    unique case (state_r)
      ST_IDLE:
        if (ncand == 2'h2)
        begin
          state_nxt = ST_JAM;
        end
        else if (ncand == 2'h1)
        begin
          state_nxt = ST_FWD;
          src_nxt = onehot_idx(cand);
          err_nxt = 1'b0;
          in_frame_nxt = 1'b0;
        end
      ST_FWD:
        if (ncand == 2'h2)
        begin
          state_nxt = ST_JAM;
        end
        else if (!cand[src_r])
        begin
          state_nxt = ST_IDLE;
        end
      ST_JAM:
        if (ncand == 2'h0)
        begin
          state_nxt = ST_IDLE;
        end
    endcase
    fwd_sym = i_rx_sym[src_nxt];
    // Data words before the start delimiter are relayed as fresh preamble of the out type.
    if (!in_frame_nxt && fwd_sym == SYM_DATA)
    begin
      fwd_sym = SYM_PRE;
    end
    if (state_nxt == ST_FWD)
    begin
      if (fwd_sym == SYM_SFD)
      begin
        in_frame_nxt = 1'b1;
      end
      else if (fwd_sym == SYM_EOF)
      begin
        in_frame_nxt = 1'b0;
      end
      // A lost word, a bad code or a reported error poisons the rest of the packet.
      if (i_rx_err[src_nxt] || fwd_sym == SYM_BAD || false_r[src_nxt] || !bif.wr_ready)
      begin
        err_nxt = 1'b1;
      end
    end
    if (err_nxt)
    begin
      fwd_sym = SYM_BAD;
    end
    col_end = (state_r == ST_JAM) && (state_nxt == ST_IDLE);
    clean_end = (state_r == ST_FWD) && (state_nxt == ST_IDLE);
  end

  // Words enter the buffer as they arrive; the buffer only absorbs stalls.
  assign bif.wr_valid = (state_nxt == ST_FWD);
  assign bif.wr_data = '{sym: fwd_sym, data: i_rx_data[src_nxt]};
  assign bif.flush = (state_nxt == ST_JAM) && (state_r != ST_JAM);
  assign bif.rd_ready = i_tx_ready && (state_r != ST_JAM);

  // Per-port protection: jabber cut-off, false carrier, link unstable and partition.
  always_comb
  begin
    for (int p = 0; p < N_PORTS; p++)
    begin
      jab_cnt_nxt[p] = act[p] ? jab_cnt_r[p] + {15'h0, jab_cnt_r[p] != 16'hffff} : 16'h0;
      jab_nxt[p] = act[p] && (jab_r[p] || jab_cnt_r[p] >= JAB_CYC - 16'h1);
      in_evt_nxt[p] = act[p];
      fc_cnt_nxt[p] = fc_cnt_r[p];
      fc_tmr_nxt[p] = fc_tmr_r[p];
      false_nxt[p] = act[p] && false_r[p];
      solo_nxt[p] = solo_r[p] && (nact != 2'h2);
      // A stream not opening with preamble or delimiter is a false carrier event.
      if (act[p] && !in_evt_r[p])
      begin
        false_nxt[p] = (i_rx_sym[p] != SYM_PRE) && (i_rx_sym[p] != SYM_SFD);
        fc_tmr_nxt[p] = 16'h0;
        solo_nxt[p] = (nact == 2'h1);
        if (false_nxt[p])
        begin
          fc_cnt_nxt[p] = fc_cnt_r[p] + {3'h0, fc_cnt_r[p] != 4'hf};
        end
        else
        begin
          fc_cnt_nxt[p] = 4'h0;
        end
      end
      else if (act[p] && false_r[p])
      begin
        fc_tmr_nxt[p] = fc_tmr_r[p] + {15'h0, fc_tmr_r[p] != 16'hffff};
      end
      idle_cnt_nxt[p] = act[p] ? 16'h0 : idle_cnt_r[p] + {15'h0, idle_cnt_r[p] != 16'hffff};
      unst_nxt[p] = unst_r[p];
      if (!act[p] && idle_cnt_r[p] >= IDLE_CYC - 16'h1)
      begin
        unst_nxt[p] = 1'b0;
        fc_cnt_nxt[p] = 4'h0;
      end
      // Setting the unstable state wins over the idle exit.
      if (fc_cnt_r[p] > FCC_LIM || fc_tmr_r[p] >= FC_CYC)
      begin
        unst_nxt[p] = 1'b1;
      end
      seen_nxt[p] = (state_r == ST_JAM) && (seen_r[p] || (act[p] && !part_r[p]));
      part_cnt_nxt[p] = part_cnt_r[p];
      part_nxt[p] = part_r[p];
      if (col_end && seen_nxt[p] && part_cnt_r[p] != 6'h3f)
      begin
        part_cnt_nxt[p] = part_cnt_r[p] + 6'h1;
      end
      if (clean_end && src_r == IW'(p))
      begin
        part_cnt_nxt[p] = 6'h0;
      end
      if (col_end && seen_nxt[p] && part_cnt_r[p] >= PART_LIM - 6'h1)
      begin
        part_nxt[p] = 1'b1;
      end
      // Reconnect after a stream on the isolated port that met no other traffic.
      if (part_r[p] && in_evt_r[p] && !act[p] && solo_r[p])
      begin
        part_nxt[p] = 1'b0;
        part_cnt_nxt[p] = 6'h0;
      end
    end
  end

  // Output stage: jam to all, buffered words to all but the source, else idle.
  always_comb
  begin
    for (int p = 0; p < N_PORTS; p++)
    begin
      tx_sym_nxt[p] = tx_sym_r[p];
      tx_code_nxt[p] = tx_code_r[p];
      if (i_tx_ready)
      begin
        if (state_r == ST_JAM)
        begin
          tx_sym_nxt[p] = SYM_JAM;
        end
        else if (bif.rd_valid && src_r != IW'(p))
        begin
          tx_sym_nxt[p] = bif.rd_data.sym;
        end
        else
        begin
          tx_sym_nxt[p] = SYM_IDLE;
        end
        tx_code_nxt[p] = encode(i_phy_type[p], tx_sym_nxt[p], bif.rd_data.data);
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state_r <= ST_IDLE;
      src_r <= '0;
      err_r <= 1'b0;
      in_frame_r <= 1'b0;
      in_evt_r <= '0;
      false_r <= '0;
      seen_r <= '0;
      solo_r <= '0;
      part_r <= '0;
      jab_r <= '0;
      unst_r <= '1;
      for (int p = 0; p < N_PORTS; p++)
      begin
        jab_cnt_r[p] <= 16'h0;
        fc_tmr_r[p] <= 16'h0;
        idle_cnt_r[p] <= 16'h0;
        fc_cnt_r[p] <= 4'h0;
        part_cnt_r[p] <= 6'h0;
        tx_sym_r[p] <= SYM_IDLE;
        tx_code_r[p] <= `RPC_CODE_IDLE;
      end
    end
    else
    begin
      state_r <= state_nxt;
      src_r <= src_nxt;
      err_r <= err_nxt;
      in_frame_r <= in_frame_nxt;
      in_evt_r <= in_evt_nxt;
      false_r <= false_nxt;
      seen_r <= seen_nxt;
      solo_r <= solo_nxt;
      part_r <= part_nxt;
      jab_r <= jab_nxt;
      unst_r <= unst_nxt;
      jab_cnt_r <= jab_cnt_nxt;
      fc_tmr_r <= fc_tmr_nxt;
      idle_cnt_r <= idle_cnt_nxt;
      fc_cnt_r <= fc_cnt_nxt;
      part_cnt_r <= part_cnt_nxt;
      tx_sym_r <= tx_sym_nxt;
      tx_code_r <= tx_code_nxt;
    end
  end

  // Status and transmit outputs come from flops; o_tx_valid and o_collision are decoded from registered state.
  always_comb
  begin
    for (int p = 0; p < N_PORTS; p++)
    begin
      o_tx_sym[p] = tx_sym_r[p];
      o_tx_code[p] = tx_code_r[p];
      o_tx_valid[p] = (tx_sym_r[p] != SYM_IDLE);
    end
  end
  assign o_collision = (state_r == ST_JAM);
  assign o_partitioned = part_r;
  assign o_jabber = jab_r;
  assign o_unstable = unst_r;

  a_jam_on_contention: assert property ((ncand == 2'h2) |=> (state_r == ST_JAM))
    else $error("Contention did not enter the collision state.");
  a_idle_exit: assert property ((state_r == ST_JAM && ncand == 2'h0) |=> state_r == ST_IDLE)
    else $error("Collision state held with no activity.");
  a_fair_pick: assert property ((state_r == ST_IDLE && ncand == 2'h1) |=>
    (state_r == ST_FWD && $past(cand) == (N_PORTS'(1) << src_r)))
    else $error("Forwarding source is not the lone active port.");
  a_push_eligible: assert property (bif.wr_valid |-> cand[src_nxt])
    else $error("Forwarding from a blocked port.");
  a_err_sticky: assert property ((err_r && state_r == ST_FWD && state_nxt == ST_FWD) |->
    (bif.wr_data.sym == SYM_BAD) ##1 err_r)
    else $error("Error substitution stopped inside a packet.");
  a_err_passed: assert property ((state_nxt == ST_FWD && i_rx_err[src_nxt]) |->
    (bif.wr_data.sym == SYM_BAD))
    else $error("Received error not sent on as invalid code.");
  a_fc_unstable: assert property ((fc_cnt_r[0] > FCC_LIM) |=> unst_r[0])
    else $error("Too many false carriers left port 0 stable.");

  for (genvar g = 0; g < N_PORTS; g++)
  begin : g_chk
    a_jam_all: assert property ((state_r == ST_JAM && i_tx_ready) |=>
      (o_tx_sym[g] == SYM_JAM && o_tx_code[g] == `RPC_CODE_JAM))
      else $error("Jam not driven on a port.");
    a_no_echo: assert property ((state_r == ST_FWD && i_tx_ready && src_r == IW'(g)) |=>
      o_tx_sym[g] == SYM_IDLE || $past(state_nxt) == ST_JAM || o_tx_sym[g] == SYM_JAM)
      else $error("Frame echoed back to its source.");
    a_jabber_cut: assert property ((act[g] && jab_cnt_r[g] >= JAB_CYC - 16'h1) |=>
      jab_r[g])
      else $error("Long stream not cut off.");
    a_partition: assert property ((col_end && seen_nxt[g] &&
      part_cnt_r[g] == PART_LIM - 6'h1) |=> part_r[g])
      else $error("Port not partitioned at the collision limit.");
  end

  c_forward: cover property (state_r == ST_FWD ##1 state_r == ST_IDLE);
  c_jam: cover property (state_r == ST_FWD ##1 state_r == ST_JAM);
  c_error: cover property (state_r == ST_FWD && err_r);
  c_stall: cover property (bif.wr_valid && !bif.wr_ready);

endmodule // rpc_core

// File: rpc_phy_model.sv
`timescale 1ns/100ps
`include "rpc_defs.svh"

// Behavioural stand-in for the physical layers on every port of the core.
module rpc_phy_model
  import rpc_pkg::*;
#(
  parameter int N = 4
)
(
  // Clock.
  input wire logic i_clk,
  // Primitives towards the core.
  output logic [N-1:0] o_rx_carrier,
  output logic [N-1:0] o_rx_link,
  output logic [N-1:0] o_rx_err,
  output rpc_sym_e o_rx_sym [N],
  output logic [`RPC_DW-1:0] o_rx_data [N],
  output logic o_tx_ready,
  // Primitives from the core.
  input wire logic [N-1:0] i_tx_valid,
  input wire rpc_sym_e i_tx_sym [N],
  input wire logic [`RPC_DW-1:0] i_tx_code [N]
);
  rpc_ent_s seen [N][$];
  logic [N-1:0] busy = '0;
  logic stall = 1'b0;
  int cyc = 0;

  // Quiet start: no carrier, links up, receivers ready.
  initial
  begin
    o_rx_carrier = '0;
    o_rx_link = '1;
    o_rx_err = '0;
    o_tx_ready = 1'b1;
    for (int p = 0; p < N; p++)
    begin
      o_rx_sym[p] = SYM_IDLE;
      o_rx_data[p] = 4'h0;
    end
  end

  // Idle ports toggle their data so a stale word can never pass for a fresh one.
  always @(posedge i_clk)
  begin
    #1;
    cyc++;
    o_tx_ready = !(stall && (cyc % 3 == 0));
    // One stall per request: a full-rate stream leaves no room to absorb a second one.
    if (!o_tx_ready)
      stall = 1'b0;
    for (int p = 0; p < N; p++)
      if (!busy[p])
        o_rx_data[p] = ~o_rx_data[p];
  end

  // Every element accepted by the receivers is logged per port.
  always @(posedge i_clk)
  begin
    for (int p = 0; p < N; p++)
      if (o_tx_ready && i_tx_valid[p])
        seen[p].push_back('{i_tx_sym[p], i_tx_code[p]});
  end

  // One receive event; npre below zero gives an event without a valid opening.
  task automatic frame(input int p, input int npre, input int ndat, input int errat);
    int n;
    rpc_sym_e s;
    busy[p] = 1'b1;
    n = (npre < 0) ? ndat : npre + ndat + 2;
    for (int i = 0; i < n; i++)
    begin
      @(posedge i_clk);
      #1;
      s = (npre < 0) ? SYM_DATA : (i < npre) ? SYM_PRE : (i == npre) ? SYM_SFD :
          (i < n - 1) ? SYM_DATA : SYM_EOF;
      o_rx_carrier[p] = 1'b1;
      o_rx_sym[p] = s;
      o_rx_data[p] = 4'(i + 1);
      o_rx_err[p] = (i == errat);
    end
    @(posedge i_clk);
    #1;
    o_rx_carrier[p] = 1'b0;
    o_rx_sym[p] = SYM_IDLE;
    o_rx_err[p] = 1'b0;
    busy[p] = 1'b0;
  endtask
endmodule // rpc_phy_model

// File: rpc_core_tb.sv
`timescale 1ns/100ps
`include "rpc_defs.svh"

module rpc_core_tb;
  import rpc_pkg::*;
  localparam int N = 4;
  localparam logic [15:0] JAB = 16'h0014;
  localparam logic [15:0] FCC = 16'h0008;
  localparam logic [15:0] IDL = 16'h000a;
  logic clk;
  logic rst;
  logic [N-1:0] carrier, link, err, tx_valid, part, jab, unst;
  rpc_sym_e rx_sym [N];
  rpc_sym_e tx_sym [N];
  logic [3:0] rx_data [N];
  logic [3:0] tx_code [N];
  rpc_phy_t ptype [N];
  logic ready, coll;
  int fails = 0;
  int n_compared = 0;
  int k;

  // Short timer values keep the protection scenarios brief.
  rpc_core #(.N_PORTS(N), .JAB_CYC(JAB), .FC_CYC(FCC), .IDLE_CYC(IDL)) rpc_core_i (
    .i_clk(clk), .i_rst(rst), .i_rx_carrier(carrier), .i_rx_link(link), .i_rx_err(err),
    .i_rx_sym(rx_sym), .i_rx_data(rx_data), .i_phy_type(ptype), .i_tx_ready(ready),
    .o_tx_valid(tx_valid), .o_tx_sym(tx_sym), .o_tx_code(tx_code), .o_collision(coll),
    .o_partitioned(part), .o_jabber(jab), .o_unstable(unst));

  rpc_phy_model #(.N(N)) rpc_phy_model_i (
    .i_clk(clk), .o_rx_carrier(carrier), .o_rx_link(link), .o_rx_err(err),
    .o_rx_sym(rx_sym), .o_rx_data(rx_data), .o_tx_ready(ready), .i_tx_valid(tx_valid),
    .i_tx_sym(tx_sym), .i_tx_code(tx_code));

  // Free-running core clock.
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    if (fails == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  // A wait that ran out of its bound ends the run as a failure.
  task automatic expire(input int lim);
    if (k >= lim)
    begin
      fails++;
      report_and_stop();
    end
  endtask

  task automatic clear();
    for (int q = 0; q < N; q++)
      rpc_phy_model_i.seen[q].delete();
  endtask

  function automatic logic [3:0] ecode(input rpc_phy_t t, input rpc_sym_e s, input logic [3:0] d);
    case (s)
      SYM_PRE: return (t == 2'h0) ? `RPC_CODE_PRE_T0 : (t == 2'h1) ? `RPC_CODE_PRE_T1 :
                      `RPC_CODE_PRE_T2;
      SYM_SFD: return `RPC_CODE_SFD;
      SYM_EOF: return `RPC_CODE_EOF;
      SYM_BAD: return (t == 2'h0) ? `RPC_CODE_BAD_T0 : (t == 2'h1) ? `RPC_CODE_BAD_T1 :
                      `RPC_CODE_BAD_T2;
      SYM_JAM: return `RPC_CODE_JAM;
      SYM_DATA: return d;
      default: return `RPC_CODE_IDLE;
    endcase
  endfunction

  // Compares what every other port received against the sent event.
  task automatic check_fwd(input int src, input int npre, input int ndat, input int errat);
    int n;
    rpc_sym_e s;
    n = npre + ndat + 2;
    for (int q = 0; q < N; q++)
    begin
      chk(rpc_phy_model_i.seen[q].size(), (q == src) ? 0 : n);
      if (q != src && rpc_phy_model_i.seen[q].size() == n)
        for (int i = 0; i < n; i++)
        begin
          s = (i < npre) ? SYM_PRE : (i == npre) ? SYM_SFD : (i < n - 1) ? SYM_DATA : SYM_EOF;
          if (errat >= 0 && i >= errat)
            s = SYM_BAD;
          chk(rpc_phy_model_i.seen[q][i], {s, ecode(ptype[q], s, 4'(i + 1))});
        end
    end
  endtask

  task automatic t_reset();
    chk({tx_valid, coll, part, unst}, {4'h0, 1'b0, 4'h0, 4'hf});
    @(posedge clk);
    #1;
    rst = 1'b0;
    tick(IDL + 4);
    chk(unst, 4'h0);
  endtask

  task automatic t_collide();
    fork
      rpc_phy_model_i.frame(1, 2, 6, -1);
      rpc_phy_model_i.frame(2, 2, 6, -1);
      begin
        for (k = 0; k < 6 && coll !== 1'b1; k++)
          tick(1);
        expire(6);
        tick(2);
        for (int q = 0; q < N; q++)
          chk({tx_sym[q], tx_code[q]}, {SYM_JAM, `RPC_CODE_JAM});
      end
    join
    for (k = 0; k < 4 && coll !== 1'b0; k++)
      tick(1);
    expire(4);
    tick(2);
    chk(tx_valid, 4'h0);
  endtask

  task automatic t_forward();
    for (int src = 0; src < N; src++)
    begin
      clear();
      rpc_phy_model_i.frame(src, 3, 4, -1);
      tick(6);
      check_fwd(src, 3, 4, -1);
    end
    clear();
    // The stall request is raised mid-frame so that the buffer really absorbs it.
    fork
      rpc_phy_model_i.frame(1, 2, 8, -1);
      begin
        tick(4);
        rpc_phy_model_i.stall = 1'b1;
      end
    join
    tick(10);
    rpc_phy_model_i.stall = 1'b0;
    check_fwd(1, 2, 8, -1);
    clear();
    rpc_phy_model_i.frame(2, 2, 5, 4);
    tick(6);
    check_fwd(2, 2, 5, 4);
  endtask

  // Output must begin long before a twenty-word frame has fully arrived.
  task automatic t_cut();
    fork
      rpc_phy_model_i.frame(0, 2, 20, -1);
      begin
        for (k = 0; k < 4 && tx_valid[1] !== 1'b1; k++)
          tick(1);
        expire(4);
      end
    join
    tick(4);
  endtask

  task automatic t_jabber();
    fork
      rpc_phy_model_i.frame(0, 2, 30, -1);
      begin
        for (k = 0; k < JAB + 8 && jab[0] !== 1'b1; k++)
          tick(1);
        expire(JAB + 8);
      end
    join
    tick(3);
    chk(jab, 4'h0);
  endtask

  task automatic t_false();
    rpc_phy_model_i.frame(1, -1, FCC + 4, -1);
    tick(1);
    chk(unst[1], 1'b1);
    clear();
    rpc_phy_model_i.frame(1, 3, 4, -1);
    tick(4);
    chk(rpc_phy_model_i.seen[0].size(), 0);
    tick(IDL + 4);
    chk(unst[1], 1'b0);
  endtask

  task automatic t_part();
    for (int i = 1; i <= 30; i++)
    begin
      fork
        rpc_phy_model_i.frame(2, 2, 2, -1);
        rpc_phy_model_i.frame(3, 2, 2, -1);
      join
      tick(4);
      if (i == 29)
        chk(part, 4'h0);
    end
    chk(part, 4'hc);
    clear();
    rpc_phy_model_i.frame(3, 2, 4, -1);
    tick(4);
    chk(rpc_phy_model_i.seen[0].size(), 0);
    chk(part[3], 1'b0);
  endtask

  // Reset, then the scenarios in an order that keeps collision counts consecutive.
  initial
  begin
    rst = 1'b1;
    for (int q = 0; q < N; q++)
      ptype[q] = 2'(q);
    repeat (16) @(posedge clk);
    t_reset();
    t_collide();
    t_forward();
    t_cut();
    t_jabber();
    t_false();
    t_part();
    report_and_stop();
  end
endmodule // rpc_core_tb
